// ### common/fbedm_map.svh
`ifndef FBEDM_MAP_SVH
`define FBEDM_MAP_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define FBEDM_CLK_HZ 32'h017D7840
`define FBEDM_DIAG_STEP_MS 32'h00000064
`define FBEDM_DIAG_STEP_CYCLES (`FBEDM_DIAG_STEP_MS * (`FBEDM_CLK_HZ / 32'h000003E8))
// ----------------------------------------
// scaling and cyclic fields
// ----------------------------------------
`define FBEDM_SF_UNIT 64'sh00000000000003E8
`define FBEDM_SF_RESET 32'sh000003E8
`define FBEDM_PRESET_FLAG_BIT 31
`define FBEDM_CTRL_LASER_BIT 0
`define FBEDM_CTRL_EXTDIAG_BIT 1
`define FBEDM_CTRL_DEMAND_BIT 2
`define FBEDM_CTRL_DISPCTL_BIT 3
`define FBEDM_CTRL_DISPON_BIT 4
`define FBEDM_PRESET_LAST 3'h4
`define FBEDM_CTRL_OCTET 3'h5
// ----------------------------------------
// parameter telegram octets (1-based)
// ----------------------------------------
`define FBEDM_PRM_DEVSPEC 8'h09
`define FBEDM_DEV_CLASS2_BIT 1
`define FBEDM_DEV_COMM_BIT 2
`define FBEDM_PRM_MODE_OCT 8'h1A
`define FBEDM_ERR_LO 2
`define FBEDM_MODE_LO 5
`define FBEDM_PRM_OFS_END 8'h29
`define FBEDM_PRM_SF_END 8'h2D
`define FBEDM_PRM_MWMIN_END 8'h31
`define FBEDM_PRM_MWMAX_END 8'h35
`define FBEDM_PRM_DIAG_END 8'h37
// ----------------------------------------
// configuration identifiers
// ----------------------------------------
`define FBEDM_CFG_D1 16'hD100
`define FBEDM_CFG_F1 16'hF100
`define FBEDM_CFG_D3 16'hD300
`define FBEDM_CFG_D3E1 16'hD3E1
`define FBEDM_CFG_98A4 16'h98A4
`define FBEDM_IN_LEN_RESET 4'h4
`endif

// ### common/fbedm_pkg.sv
package fbedm_pkg;
	typedef enum logic [1:0] {
		FBEDM_ERR_HOLD = 2'h0,
		FBEDM_ERR_MIN = 2'h1,
		FBEDM_ERR_MAX = 2'h2,
		FBEDM_ERR_RSV = 2'h3
	} fbedm_err_e;
	typedef enum logic [2:0] {
		single_distance_mode = 3'h0,
		continuous_track_mode = 3'h1,
		timed_measure_mode = 3'h2
	} fbedm_mode_e;
	typedef enum logic [1:0] {
		FBEDM_TX_IDLE = 2'h1,
		FBEDM_TX_SEND = 2'h2
	} fbedm_tx_e;
	typedef struct packed {
		logic [7:0] idx;
		logic [31:0] sh;
		logic class2_en;
		logic comm_diag_en;
		logic [1:0] err_react;
		logic [2:0] meas_mode;
		logic [15:0] diag_interval;
		logic [31:0] ofs;
		logic ofs_load;
		logic [31:0] sf;
		logic [31:0] mw_min;
		logic [31:0] mw_max;
	} fbedm_prm_s;
	typedef struct packed {
		logic cfg_ok;
		logic [3:0] in_len;
		logic [2:0] out_len;
		logic [2:0] out_idx;
		logic [31:0] preset;
		logic [31:0] offset;
		logic offset_upd;
		logic [4:0] ctrl;
		logic [31:0] pos;
		fbedm_tx_e tx_st;
		logic [3:0] tx_cnt;
		logic [71:0] tx_buf;
		logic [31:0] step_cnt;
		logic [15:0] diag_steps;
		logic diag_due;
	} fbedm_top_s;
endpackage

// ### common/fbedm_prm_if.sv
`timescale 1ns/10ps
interface fbedm_prm_if;
	logic [7:0] prm_byte;
	logic prm_valid;
	logic prm_first;
	logic class2_en;
	logic comm_diag_en;
	logic [1:0] err_react;
	logic [2:0] meas_mode;
	logic [15:0] diag_interval;
	logic [31:0] ofs_value;
	logic ofs_load;
	logic [31:0] scale_factor_param;
	logic [31:0] mw_min;
	logic [31:0] mw_max;
	modport dec (
		input prm_byte, prm_valid, prm_first,
		output class2_en, comm_diag_en, err_react, meas_mode, diag_interval,
		output ofs_value, ofs_load, scale_factor_param, mw_min, mw_max
	);
	modport use_side (
		output prm_byte, prm_valid, prm_first,
		input class2_en, comm_diag_en, err_react, meas_mode, diag_interval,
		input ofs_value, ofs_load, scale_factor_param, mw_min, mw_max
	);
endinterface

// ### hw/fbedm_prm_dec.sv
`timescale 1ns/10ps
`include "fbedm_map.svh"
module fbedm_prm_dec (
	input wire logic clock_in,
	input wire logic rst_n_in,
	fbedm_prm_if.dec prm
);
	fbedm_pkg::fbedm_prm_s q;
	fbedm_pkg::fbedm_prm_s next_q;
	logic [31:0] word;

	// ----------------------------------------
	// octet walker
	// ----------------------------------------
	always_comb begin
		next_q = q;
		next_q.ofs_load = 1'b0;
		word = {q.sh[23:0], prm.prm_byte};
		if (prm.prm_valid) begin
			next_q.idx = prm.prm_first ? 8'h01 : q.idx + 8'h01;
			next_q.sh = word;
			case (next_q.idx)
				`FBEDM_PRM_DEVSPEC: begin
					next_q.class2_en = prm.prm_byte[`FBEDM_DEV_CLASS2_BIT];
					next_q.comm_diag_en = prm.prm_byte[`FBEDM_DEV_COMM_BIT];
				end
				`FBEDM_PRM_MODE_OCT: begin
					next_q.err_react = prm.prm_byte[`FBEDM_ERR_LO +: 2];
					next_q.meas_mode = prm.prm_byte[`FBEDM_MODE_LO +: 3];
				end
				`FBEDM_PRM_OFS_END: begin
					next_q.ofs = word;
					next_q.ofs_load = 1'b1;
				end
				`FBEDM_PRM_SF_END: begin
					next_q.sf = word;
				end
				`FBEDM_PRM_MWMIN_END: begin
					next_q.mw_min = word;
				end
				`FBEDM_PRM_MWMAX_END: begin
					next_q.mw_max = word;
				end
				`FBEDM_PRM_DIAG_END: begin
					next_q.diag_interval = word[15:0];
				end
				// station fields and encoder-profile octets carry nothing for a linear sensor
				default: begin
					next_q.sh = word;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.sf <= `FBEDM_SF_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign prm.class2_en = q.class2_en;
	assign prm.comm_diag_en = q.comm_diag_en;
	assign prm.err_react = q.err_react;
	assign prm.meas_mode = q.meas_mode;
	assign prm.diag_interval = q.diag_interval;
	assign prm.ofs_value = q.ofs;
	assign prm.ofs_load = q.ofs_load;
	assign prm.scale_factor_param = q.sf;
	assign prm.mw_min = q.mw_min;
	assign prm.mw_max = q.mw_max;
endmodule

// ### hw/fbedm_top.sv
`timescale 1ns/10ps
`include "fbedm_map.svh"
// How it works
// - multi-octet values go out most significant first
// - octets 1-4 carry signed position
// - eight-byte layout appends signed signal level
// - nine-byte layout appends signed temperature octet
// - scale factor sets resolution and sign
// - preset top bit set loads offset, else kept
// - position equals laser value plus offset
// - parameter offset always adopted
// - control octet: laser, display master, display
// - control octet: extended and on-demand diagnostics
// - device octet: class 2, commissioning diagnostics
// - octets 1-8 are standard station fields
// - octet 26 bits 2-3 select error reaction
// - octet 26 bits 5-7 select measure mode
// - octets 54-55 diagnostic interval, 100 ms
// - encoder-profile scaling parameters are ignored
// - new offset reported for diagnostic readback
// - id 98A4 enables nine in, five out
// - id D3 selects eight-byte input layout
module fbedm_top #(
	parameter int unsigned DIAG_STEP_CYCLES = `FBEDM_DIAG_STEP_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [15:0] cfg_id_in,
	input wire logic cfg_load_in,
	output logic cfg_ok_out,
	output logic [3:0] in_len_out,
	output logic [2:0] out_len_out,
	input wire logic [7:0] out_byte_in,
	input wire logic out_valid_in,
	input wire logic out_first_in,
	input wire logic [7:0] prm_byte_in,
	input wire logic prm_valid_in,
	input wire logic prm_first_in,
	input wire logic [31:0] laser_raw_in,
	input wire logic meas_error_in,
	input wire logic [31:0] signal_level_in,
	input wire logic [7:0] temperature_in,
	input wire logic in_start_in,
	input wire logic in_ready_in,
	output logic [7:0] in_byte_out,
	output logic in_valid_out,
	output logic in_last_out,
	output logic [31:0] bus_position_value_out,
	output logic [31:0] offset_out,
	output logic offset_upd_out,
	output logic laser_on_out,
	output logic ext_diag_out,
	output logic diag_on_demand_out,
	output logic display_master_ctrl_out,
	output logic front_display_on_out,
	output logic class2_en_out,
	output logic comm_diag_en_out,
	output logic [1:0] error_reaction_select_out,
	output logic [2:0] meas_mode_out,
	output logic [15:0] diag_interval_out,
	output logic diag_due_out
);
	fbedm_pkg::fbedm_top_s q;
	fbedm_pkg::fbedm_top_s next_q;
	fbedm_prm_if prm();
	logic signed [63:0] prod;
	logic signed [31:0] scaled;
	logic signed [31:0] sum;
	logic [31:0] preset_word;
	logic [2:0] out_n;

	// ----------------------------------------
	// parameter telegram decode
	// ----------------------------------------
	assign prm.prm_byte = prm_byte_in;
	assign prm.prm_valid = prm_valid_in;
	assign prm.prm_first = prm_first_in;

	fbedm_prm_dec u_prm (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.prm(prm)
	);

	// ----------------------------------------
	// position path
	// ----------------------------------------
	always_comb begin
		prod = $signed(laser_raw_in) * $signed(prm.scale_factor_param);
		scaled = 32'(prod / `FBEDM_SF_UNIT);
		sum = scaled + $signed(q.offset);
		preset_word = {q.preset[23:0], out_byte_in};
		// saturate so trailing octets of a long telegram never wrap onto the preset
		out_n = out_first_in ? 3'h1 : (q.out_idx == 3'h7 ? 3'h7 : q.out_idx + 3'h1);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_q = q;
		next_q.offset_upd = 1'b0;
		next_q.diag_due = 1'b0;

		// configuration identifier; unknown ids keep the last layout
		if (cfg_load_in) begin
			next_q.cfg_ok = 1'b1;
			case (cfg_id_in)
				`FBEDM_CFG_D1: begin
					next_q.in_len = 4'h4;
					next_q.out_len = 3'h0;
				end
				`FBEDM_CFG_F1: begin
					next_q.in_len = 4'h4;
					next_q.out_len = 3'h4;
				end
				`FBEDM_CFG_D3: begin
					next_q.in_len = 4'h8;
					next_q.out_len = 3'h0;
				end
				`FBEDM_CFG_D3E1: begin
					next_q.in_len = 4'h8;
					next_q.out_len = 3'h4;
				end
				`FBEDM_CFG_98A4: begin
					next_q.in_len = 4'h9;
					next_q.out_len = 3'h5;
				end
				default: begin
					next_q.cfg_ok = 1'b0;
				end
			endcase
		end

		// cyclic output octets; the preset only counts once all four arrived
		if (out_valid_in) begin
			next_q.out_idx = out_n;
			if (out_n <= `FBEDM_PRESET_LAST) begin
				next_q.preset = preset_word;
			end
			if (out_n == `FBEDM_PRESET_LAST && preset_word[`FBEDM_PRESET_FLAG_BIT]) begin
				// flag bit is not part of the value; bit 30 carries the sign
				next_q.offset = {preset_word[30], preset_word[30:0]};
				next_q.offset_upd = 1'b1;
			end
			if (out_n == `FBEDM_CTRL_OCTET && q.out_len == `FBEDM_CTRL_OCTET) begin
				next_q.ctrl = out_byte_in[4:0];
			end
		end

		// parameter offset arrives last in time, so it wins a tie
		if (prm.ofs_load) begin
			next_q.offset = prm.ofs_value;
			next_q.offset_upd = 1'b1;
		end

		// position register refreshes every cycle unless a measurement error with hold or reserved reaction keeps it
		if (!meas_error_in) begin
			next_q.pos = sum;
		end else begin
			unique case (fbedm_pkg::fbedm_err_e'(prm.err_react))
				fbedm_pkg::FBEDM_ERR_MIN: next_q.pos = prm.mw_min;
				fbedm_pkg::FBEDM_ERR_MAX: next_q.pos = prm.mw_max;
				fbedm_pkg::FBEDM_ERR_HOLD: next_q.pos = q.pos;
				fbedm_pkg::FBEDM_ERR_RSV: next_q.pos = q.pos;
			endcase
		end

		// input telegram sender; a start while busy is dropped
		unique case (q.tx_st)
			fbedm_pkg::FBEDM_TX_IDLE: begin
				if (in_start_in) begin
					next_q.tx_buf = {q.pos, signal_level_in, temperature_in};
					next_q.tx_cnt = q.in_len;
					next_q.tx_st = fbedm_pkg::FBEDM_TX_SEND;
				end
			end
			fbedm_pkg::FBEDM_TX_SEND: begin
				if (in_ready_in) begin
					next_q.tx_buf = {q.tx_buf[63:0], 8'h00};
					next_q.tx_cnt = q.tx_cnt - 4'h1;
					if (q.tx_cnt == 4'h1) begin
						next_q.tx_st = fbedm_pkg::FBEDM_TX_IDLE;
					end
				end
			end
		endcase

		// diagnostic interval timer; zero interval stops it
		if (prm.diag_interval == 16'h0000) begin
			next_q.step_cnt = 32'h00000000;
			next_q.diag_steps = 16'h0000;
		end else if (q.step_cnt == 32'(DIAG_STEP_CYCLES - 1)) begin
			next_q.step_cnt = 32'h00000000;
			if (q.diag_steps + 16'h0001 >= prm.diag_interval) begin
				next_q.diag_steps = 16'h0000;
				next_q.diag_due = 1'b1;
			end else begin
				next_q.diag_steps = q.diag_steps + 16'h0001;
			end
		end else begin
			next_q.step_cnt = q.step_cnt + 32'h00000001;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.in_len <= `FBEDM_IN_LEN_RESET;
			q.tx_st <= fbedm_pkg::FBEDM_TX_IDLE;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cfg_ok_out = q.cfg_ok;
	assign in_len_out = q.in_len;
	assign out_len_out = q.out_len;
	assign in_byte_out = q.tx_buf[71:64];
	assign in_valid_out = (q.tx_st == fbedm_pkg::FBEDM_TX_SEND);
	assign in_last_out = (q.tx_st == fbedm_pkg::FBEDM_TX_SEND) && (q.tx_cnt == 4'h1);
	assign bus_position_value_out = q.pos;
	assign offset_out = q.offset;
	assign offset_upd_out = q.offset_upd;
	assign laser_on_out = q.ctrl[`FBEDM_CTRL_LASER_BIT];
	assign ext_diag_out = q.ctrl[`FBEDM_CTRL_EXTDIAG_BIT];
	assign diag_on_demand_out = q.ctrl[`FBEDM_CTRL_DEMAND_BIT];
	assign display_master_ctrl_out = q.ctrl[`FBEDM_CTRL_DISPCTL_BIT];
	assign front_display_on_out = q.ctrl[`FBEDM_CTRL_DISPON_BIT];
	assign class2_en_out = prm.class2_en;
	assign comm_diag_en_out = prm.comm_diag_en;
	assign error_reaction_select_out = prm.err_react;
	assign meas_mode_out = prm.meas_mode;
	assign diag_interval_out = prm.diag_interval;
	assign diag_due_out = q.diag_due;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	property p_preset_load;
		out_valid_in && !out_first_in && q.out_idx == 3'h3 && q.preset[23] |=> offset_upd_out;
	endproperty
	a_preset_load: assert property (p_preset_load) else $error("flagged preset did not load offset");

	property p_preset_keep;
		out_valid_in && !out_first_in && q.out_idx == 3'h3 && !q.preset[23] && !prm.ofs_load
			|=> $stable(offset_out);
	endproperty
	a_preset_keep: assert property (p_preset_keep) else $error("unflagged preset changed offset");

	property p_pos_sum;
		!meas_error_in |=> bus_position_value_out == $past(sum);
	endproperty
	a_pos_sum: assert property (p_pos_sum) else $error("position is not laser plus offset");

	property p_prm_adopt;
		prm.ofs_load |=> offset_out == $past(prm.ofs_value) && offset_upd_out;
	endproperty
	a_prm_adopt: assert property (p_prm_adopt) else $error("parameter offset not adopted");

	property p_first_octet;
		q.tx_st == fbedm_pkg::FBEDM_TX_IDLE && in_start_in
			|=> in_valid_out && in_byte_out == $past(bus_position_value_out[31:24]);
	endproperty
	a_first_octet: assert property (p_first_octet) else $error("first octet is not position msb");

	property p_big_endian;
		in_valid_out && in_ready_in && !in_last_out |=> in_byte_out == $past(q.tx_buf[63:56]);
	endproperty
	a_big_endian: assert property (p_big_endian) else $error("octet order broken");

	property p_temp_octet;
		q.tx_st == fbedm_pkg::FBEDM_TX_IDLE && in_start_in && q.in_len == 4'h9
			|=> q.tx_buf[7:0] == $past(temperature_in) && q.tx_cnt == 4'h9;
	endproperty
	a_temp_octet: assert property (p_temp_octet) else $error("temperature octet missing");

	property p_ctrl;
		out_valid_in && !out_first_in && q.out_idx == 3'h4 && q.out_len == 3'h5
			|=> laser_on_out == $past(out_byte_in[0]) && front_display_on_out == $past(out_byte_in[4]);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control octet not decoded");

	property p_err_max;
		meas_error_in && prm.err_react == 2'h2 |=> bus_position_value_out == $past(prm.mw_max);
	endproperty
	a_err_max: assert property (p_err_max) else $error("error reaction max not applied");

	property p_cfg98;
		cfg_load_in && cfg_id_in == 16'h98A4 |=> in_len_out == 4'h9 && out_len_out == 3'h5;
	endproperty
	a_cfg98: assert property (p_cfg98) else $error("nine in five out not selected");

	property p_diag_pulse;
		diag_due_out |=> !diag_due_out [*2];
	endproperty
	a_diag_pulse: assert property (p_diag_pulse) else $error("diagnostic due not a pulse");

	property p_cfg_d3;
		cfg_load_in && cfg_id_in == `FBEDM_CFG_D3 |=> in_len_out == 4'h8 && out_len_out == 3'h0;
	endproperty
	a_cfg_d3: assert property (p_cfg_d3) else $error("eight-byte input layout not selected");

	property p_err_min;
		meas_error_in && prm.err_react == 2'h1 |=> bus_position_value_out == $past(prm.mw_min);
	endproperty
	a_err_min: assert property (p_err_min) else $error("error reaction min not applied");

	property p_err_hold;
		meas_error_in && prm.err_react == 2'h0 |=> $stable(bus_position_value_out);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error reaction hold not applied");

	property p_last_octet;
		in_valid_out && in_ready_in && in_last_out |=> !in_valid_out;
	endproperty
	a_last_octet: assert property (p_last_octet) else $error("sender kept going after last octet");

	property p_ctrl_ignore;
		out_valid_in && !out_first_in && q.out_idx == 3'h4 && q.out_len != 3'h5 |=> $stable(q.ctrl);
	endproperty
	a_ctrl_ignore: assert property (p_ctrl_ignore) else $error("control octet taken without layout");

	property p_cov_nine;
		in_last_out && in_ready_in && in_len_out == 4'h9;
	endproperty
	c_cov_nine: cover property (p_cov_nine);

	property p_cov_preset;
		offset_upd_out && !prm.ofs_load;
	endproperty
	c_cov_preset: cover property (p_cov_preset);

	property p_cov_err;
		meas_error_in ##1 !meas_error_in;
	endproperty
	c_cov_err: cover property (p_cov_err);

	property p_cov_stall;
		in_valid_out && !in_ready_in;
	endproperty
	c_cov_stall: cover property (p_cov_stall);

	property p_cov_diag;
		diag_due_out;
	endproperty
	c_cov_diag: cover property (p_cov_diag);
endmodule

// ### sim/fbedm_master_model.sv
`timescale 1ns/10ps
// ----
// far-side master: takes input telegram bytes
// ----
module fbedm_master_model (
	input wire logic clock_in,
	input wire logic clr_in,
	input wire logic stall_in,
	input wire logic [7:0] in_byte_in,
	input wire logic in_valid_in,
	input wire logic in_last_in,
	output logic in_ready_out,
	output logic [71:0] rx_data_out,
	output logic [3:0] rx_count_out,
	output logic [3:0] last_at_out
);
	logic ph;
	initial begin
		ph = 1'h0;
		in_ready_out = 1'h0;
		rx_data_out = 72'h0;
		rx_count_out = 4'h0;
		last_at_out = 4'h0;
	end
	// ready drops every other cycle when stalling, to hold the slave's bytes
	always @(posedge clock_in) begin
		if (clr_in) begin
			rx_data_out <= 72'h0;
			rx_count_out <= 4'h0;
			last_at_out <= 4'h0;
		end else if (in_valid_in === 1'h1 && in_ready_out) begin
			rx_data_out <= {rx_data_out[63:0], in_byte_in};
			rx_count_out <= rx_count_out + 4'h1;
			if (in_last_in === 1'h1) begin
				last_at_out <= rx_count_out + 4'h1;
			end
		end
		ph <= ~ph;
		in_ready_out <= #1 ~stall_in | ph;
	end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam logic [15:0] ident_code = 16'hA5C3; // arbitrary value
	localparam logic [95:0] cfg_ids = {16'hD100, 16'hF100, 16'hD300, 16'hD3E1, 16'h98A4, 16'h1234};
	localparam logic [23:0] in_tab = {4'h4, 4'h4, 4'h8, 4'h8, 4'h9, 4'h9};
	localparam logic [17:0] out_tab = {3'h0, 3'h4, 3'h0, 3'h4, 3'h5, 3'h5};
	logic clock_in, rst_n_in, cfg_load_in, out_valid_in, out_first_in, prm_valid_in, prm_first_in;
	logic meas_error_in, in_start_in, in_ready_in, clr, stall, cfg_ok_out, in_valid_out, in_last_out;
	logic offset_upd_out, laser_on_out, ext_diag_out, diag_on_demand_out, display_master_ctrl_out;
	logic front_display_on_out, class2_en_out, comm_diag_en_out, diag_due_out;
	logic [15:0] cfg_id_in, diag_interval_out;
	logic [7:0] out_byte_in, prm_byte_in, temperature_in, in_byte_out;
	logic [31:0] laser_raw_in, signal_level_in, bus_position_value_out, offset_out, ep;
	logic [3:0] in_len_out, rx_count, last_at;
	logic [2:0] out_len_out, meas_mode_out;
	logic [1:0] error_reaction_select_out;
	logic [71:0] rx_data;
	logic [7:0] bytes [0:63];
	int fail_count, tests_run, cyc, upd_cnt, c;

	fbedm_top #(.DIAG_STEP_CYCLES(4)) fbedm_top_i (.clock_in, .rst_n_in, .cfg_id_in, .cfg_load_in,
		.cfg_ok_out, .in_len_out, .out_len_out, .out_byte_in, .out_valid_in, .out_first_in,
		.prm_byte_in, .prm_valid_in, .prm_first_in, .laser_raw_in, .meas_error_in, .signal_level_in,
		.temperature_in, .in_start_in, .in_ready_in, .in_byte_out, .in_valid_out, .in_last_out,
		.bus_position_value_out, .offset_out, .offset_upd_out, .laser_on_out, .ext_diag_out,
		.diag_on_demand_out, .display_master_ctrl_out, .front_display_on_out, .class2_en_out,
		.comm_diag_en_out, .error_reaction_select_out, .meas_mode_out, .diag_interval_out, .diag_due_out);
	fbedm_master_model fbedm_master_model_i (.clock_in, .clr_in(clr), .stall_in(stall),
		.in_byte_in(in_byte_out), .in_valid_in(in_valid_out), .in_last_in(in_last_out),
		.in_ready_out(in_ready_in), .rx_data_out(rx_data), .rx_count_out(rx_count), .last_at_out(last_at));

	initial begin
		clock_in = 1'h0;
		forever #20 clock_in = ~clock_in;
	end
	// ----
	// watchdog and pulse counting
	// ----
	always @(posedge clock_in) begin
		cyc++;
		if (offset_upd_out === 1'h1) upd_cnt++;
		if (cyc == 6000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task check(input logic [71:0] seen, input logic [71:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	// inputs always change 1 ns after the rising edge
	task tick(input int k);
		repeat (k) @(posedge clock_in);
		#1;
	endtask
	function void put(input int i, input logic [31:0] v);
		{bytes[i], bytes[i+1], bytes[i+2], bytes[i+3]} = v;
	endfunction
	// valid stays up across the whole stream, so bytes go back to back
	task send(input bit prm, input int len);
		for (int i = 0; i < len; i++) begin
			if (prm) {prm_valid_in, prm_first_in, prm_byte_in} = {1'h1, i == 0, bytes[i]};
			else {out_valid_in, out_first_in, out_byte_in} = {1'h1, i == 0, bytes[i]};
			tick(1);
		end
		{prm_valid_in, prm_first_in, out_valid_in, out_first_in} = 4'h0;
		tick(1);
	endtask
	task cfg(input logic [15:0] id);
		cfg_id_in = id;
		cfg_load_in = 1'h1;
		tick(1);
		cfg_load_in = 1'h0;
		tick(1);
	endtask
	task prm_tel(input logic [1:0] err);
		for (int i = 0; i < 64; i++) bytes[i] = 8'hFF;
		{bytes[0], bytes[1], bytes[2], bytes[3]} = 32'h880A0B0B;
		{bytes[4], bytes[5], bytes[6], bytes[7]} = {ident_code, 16'h0000};
		bytes[8] = err[0] ? 8'hFF : 8'hF9;
		bytes[25] = {1'h0, err, 1'h1, err, 2'h3};
		put(37, 32'h00000014);
		put(41, 32'hFFFFFC18);
		put(45, 32'h00000064);
		put(49, 32'h000003E8);
		{bytes[53], bytes[54]} = 16'h0002;
		send(1, 55);
		tick(2);
	endtask

	initial begin
		{rst_n_in, cfg_load_in, out_valid_in, out_first_in, prm_valid_in, prm_first_in} = 6'h0;
		{meas_error_in, in_start_in, clr, stall} = 4'h0;
		{cfg_id_in, out_byte_in, prm_byte_in, temperature_in} = 40'h0;
		{laser_raw_in, signal_level_in} = 64'h0;
		fail_count = 0;
		tests_run = 0;
		cyc = 0;
		upd_cnt = 0;
		tick(2);
		rst_n_in = 1'h1;
		tick(1);
		check(in_len_out, 4'h4, "reset in_len");
		check(out_len_out, 3'h0, "reset out_len");
		check({cfg_ok_out, offset_out}, 33'h0, "reset ok/offset");
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			cfg(cfg_ids[95-16*i -: 16]);
			check(in_len_out, in_tab[23-4*i -: 4], "in_len");
			check(out_len_out, out_tab[17-3*i -: 3], "out_len");
			check(cfg_ok_out, i != 5, "cfg_ok");
		end
		$display("test config done");
		laser_raw_in = 32'h00001234;
		tick(2);
		check(bus_position_value_out, 32'h00001234, "position");
		upd_cnt = 0;
		for (int b = 0; b < 5; b++) begin
			put(0, b == 0 ? 32'h80000005 : 32'h00000009);
			bytes[4] = 8'hE0 | (8'h01 << b);
			send(0, 5);
			check({front_display_on_out, display_master_ctrl_out, diag_on_demand_out, ext_diag_out,
				laser_on_out}, 5'h01 << b, "control octet");
			check(offset_out, 32'h00000005, "offset");
		end
		check(upd_cnt, 1, "offset updates");
		check(bus_position_value_out, 32'h00001239, "position plus offset");
		cfg(16'hD3E1);
		put(0, 32'h00000000);
		bytes[4] = 8'h00;
		send(0, 5);
		check(front_display_on_out, 1'h1, "octet 5 without 5-byte layout");
		$display("test cyclic output done");
		ep = -32'sh1234 + 32'sh14;
		for (int k = 0; k < 4; k++) begin
			prm_tel(k[1:0]);
			check(error_reaction_select_out, k[1:0], "error reaction");
			check(meas_mode_out, k[2:0], "measure mode");
			check({class2_en_out, comm_diag_en_out}, {k[0], k[0]}, "device octet");
			check(diag_interval_out, 16'h0002, "diag interval");
			check(offset_out, 32'h00000014, "parameter offset");
			check(bus_position_value_out, ep, "scaled position");
			meas_error_in = 1'h1;
			laser_raw_in = 32'h00005555;
			tick(2);
			check(bus_position_value_out, k == 1 ? 32'h64 : (k == 2 ? 32'h3E8 : ep), "error value");
			meas_error_in = 1'h0;
			laser_raw_in = 32'h00001234;
			tick(2);
		end
		$display("test parameters done");
		for (c = 0; c < 40 && diag_due_out !== 1'h1; c++) tick(1);
		c = 0;
		do begin
			tick(1);
			c++;
		end while (diag_due_out !== 1'h1 && c < 40);
		check(c, 8, "diag period");
		$display("test diag timer done");
		signal_level_in = 32'h80010203;
		temperature_in = 8'hE7;
		for (int t = 0; t < 3; t++) begin
			cfg(t == 0 ? 16'hD100 : (t == 1 ? 16'hD300 : 16'h98A4));
			clr = 1'h1;
			stall = t[0];
			tick(1);
			clr = 1'h0;
			in_start_in = 1'h1;
			tick(1);
			in_start_in = 1'h0;
			for (int w = 0; w < 60 && rx_count !== in_len_out; w++) tick(1);
			tick(2);
			check(rx_count, in_len_out, "input byte count");
			check(last_at, in_len_out, "last byte mark");
			check(rx_data, {ep, signal_level_in, temperature_in} >> (8 * (9 - in_len_out)),
				"input telegram");
		end
		$display("test input telegram done");
		report_and_stop();
	end
endmodule
